// *** core/tcr_pkg.sv ***
package tcr_pkg;

	// Register offsets (byte addresses on the host bus)
	localparam logic [6:0] A_ID_LO   = 7'h00;
	localparam logic [6:0] A_ID_HI   = 7'h01;
	localparam logic [6:0] A_REV     = 7'h02;
	localparam logic [6:0] A_SUBREV  = 7'h03;
	localparam logic [6:0] A_MS      = 7'h04;
	localparam logic [6:0] A_PH0_LO  = 7'h05;
	localparam logic [6:0] A_PH0_HI  = 7'h06;
	localparam logic [6:0] A_PH1_LO  = 7'h07;
	localparam logic [6:0] A_PH1_HI  = 7'h08;
	localparam logic [6:0] A_FILL    = 7'h09;
	localparam logic [6:0] A_LEAK    = 7'h0A;
	localparam logic [6:0] A_BKT     = 7'h0B;
	localparam logic [6:0] A_ASET    = 7'h0C;
	localparam logic [6:0] A_ACLR    = 7'h0D;
	localparam logic [6:0] A_TRIM_LO = 7'h0E;
	localparam logic [6:0] A_TRIM_HI = 7'h0F;
	localparam logic [6:0] A_REJ_LO  = 7'h10;
	localparam logic [6:0] A_REJ_HI  = 7'h11;
	localparam logic [6:0] A_ACC_LO  = 7'h12;
	localparam logic [6:0] A_ACC_HI  = 7'h13;
	localparam logic [6:0] A_MODE0   = 7'h1C;
	localparam logic [6:0] A_EVT_LO  = 7'h5E;
	localparam logic [6:0] A_EVT_HI  = 7'h5F;

	// Values after reset
	localparam logic [11:0] RST_PHASE = 12'h000;
	localparam logic [3:0]  RST_FILL  = 4'h1;
	localparam logic [3:0]  RST_LEAK  = 4'h3;
	localparam logic [5:0]  RST_BKT   = 6'h14;
	localparam logic [5:0]  RST_ASET  = 6'h0F;
	localparam logic [5:0]  RST_ACLR  = 6'h0A;
	localparam logic [10:0] RST_TRIM  = 11'h000;
	localparam logic [10:0] RST_REJ   = 11'h06E;
	localparam logic [10:0] RST_ACC   = 11'h064;
	localparam logic [5:0]  RST_MODE0 = 6'h00;

	// Identity values, arbitrary
	localparam logic [15:0] ID_CODE    = 16'hA5C3;
	localparam logic [7:0]  REV_CODE   = 8'h5A;
	localparam logic [7:0]  SUBREV_CODE = 8'h3C;

	// Mode register field positions
	localparam int MODE_OOP_BIT  = 5;
	localparam int MODE_AUTO_BIT = 4;

	// Millisecond tick timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

	// Host bus pins as sampled
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [6:0] addr;
		logic [7:0] data;
	} tcr_pins_s;

endpackage

// *** core/tcr_register_bank.sv ***
`timescale 1ns/1ps

module tcr_register_bank #(
	parameter int P_MS_CYCLES = tcr_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Host bus pins
	input  wire logic        i_bus_cs_n,
	input  wire logic        i_bus_rd_n,
	input  wire logic        i_bus_wr_n,
	input  wire logic [6:0]  i_bus_addr,
	input  wire logic [7:0]  i_bus_ad,
	output logic      [7:0]  o_bus_ad,
	output logic             o_bus_ad_oe_n,
	// Device pins and status
	input  wire logic [1:0]  i_ms_sel,
	input  wire logic        i_ref_activity,
	input  wire logic [15:0] i_event,
	input  wire logic [10:0] i_ref_offset,
	// Settings and status to the device core
	output logic      [11:0] o_gen0_phase_adj,
	output logic      [11:0] o_gen1_phase_adj,
	output logic      [10:0] o_freerun_trim,
	output logic      [10:0] o_reject_range,
	output logic      [10:0] o_accept_range,
	output logic      [5:0]  o_gen0_mode,
	output logic      [15:0] o_event,
	output logic             o_activity_alarm,
	output logic             o_ref_follow
);

	tcr_pkg::tcr_pins_s pin_s1_r, pin_s2_r, pin_prev_r;
	logic [1:0]  ms_s1_r, ms_s2_r;
	logic        act_s1_r, act_s2_r;
	logic [7:0]  rd_hold_r, wr_hold_r, ad_r;
	logic        ad_oe_n_r;
	logic [11:0] ph0_r, ph1_r;
	logic [3:0]  fill_r, leak_r;
	logic [5:0]  bkt_r, aset_r, aclr_r, mode0_r;
	logic [10:0] trim_r, rej_r, acc_r;
	logic [15:0] evt_r, evt_nxt;
	logic [14:0] ms_cnt_r;
	logic [3:0]  fill_cnt_r, leak_cnt_r;
	logic [5:0]  bucket_r, bucket_nxt;
	logic        seen_r, alarm_r, follow_r;
	logic [15:0] val16;

	// Pin synchronisers and edge history
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_s1_r   <= '1;
			pin_s2_r   <= '1;
			pin_prev_r <= '1;
			ms_s1_r    <= 2'h0;
			ms_s2_r    <= 2'h0;
			act_s1_r   <= 1'b0;
			act_s2_r   <= 1'b0;
		end else begin
			pin_s1_r   <= {i_bus_cs_n, i_bus_rd_n, i_bus_wr_n, i_bus_addr, i_bus_ad};
			pin_s2_r   <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
			ms_s1_r    <= i_ms_sel;
			ms_s2_r    <= ms_s1_r;
			act_s1_r   <= i_ref_activity;
			act_s2_r   <= act_s1_r;
		end
	end

	// Access decode: read on strobe fall, write on strobe rise
	wire        rd_take = !pin_s2_r.cs_n && !pin_s2_r.rd_n && pin_prev_r.rd_n;
	wire        wr_take = !pin_prev_r.cs_n && pin_s2_r.wr_n && !pin_prev_r.wr_n;
	wire        rd_act  = !pin_s2_r.cs_n && !pin_s2_r.rd_n;
	wire [6:0]  raddr   = pin_s2_r.addr;
	wire [6:0]  waddr   = pin_prev_r.addr;
	wire [7:0]  wdata   = pin_prev_r.data;
	wire        r_is_lo = (raddr == tcr_pkg::A_ID_LO) || (raddr == tcr_pkg::A_PH0_LO) ||
		(raddr == tcr_pkg::A_PH1_LO) || (raddr == tcr_pkg::A_TRIM_LO) ||
		(raddr == tcr_pkg::A_REJ_LO) || (raddr == tcr_pkg::A_ACC_LO) ||
		(raddr == tcr_pkg::A_EVT_LO);
	wire        r_is_hi = (raddr == tcr_pkg::A_ID_HI) || (raddr == tcr_pkg::A_PH0_HI) ||
		(raddr == tcr_pkg::A_PH1_HI) || (raddr == tcr_pkg::A_TRIM_HI) ||
		(raddr == tcr_pkg::A_REJ_HI) || (raddr == tcr_pkg::A_ACC_HI) ||
		(raddr == tcr_pkg::A_EVT_HI);
	wire        w_is_lo = (waddr == tcr_pkg::A_PH0_LO) || (waddr == tcr_pkg::A_PH1_LO) ||
		(waddr == tcr_pkg::A_TRIM_LO) || (waddr == tcr_pkg::A_REJ_LO) ||
		(waddr == tcr_pkg::A_ACC_LO) || (waddr == tcr_pkg::A_EVT_LO);
	wire [15:0] wval    = {wdata, wr_hold_r};
	wire        wr_at   = wr_take;
	wire        bkt_ok  = wdata[5:0] >= aset_r;
	wire        aset_ok = (wdata[5:0] > aclr_r) && (wdata[5:0] <= bkt_r);
	wire        aclr_ok = wdata[5:0] < aset_r;
	wire [15:0] evt_clr = (wr_at && waddr == tcr_pkg::A_EVT_HI) ? wval : 16'h0000;

	// Full value of the register holding the read address
	always_comb begin
		case (raddr)
			tcr_pkg::A_ID_LO:   val16 = tcr_pkg::ID_CODE;
			tcr_pkg::A_REV:     val16 = {8'h00, tcr_pkg::REV_CODE};
			tcr_pkg::A_SUBREV:  val16 = {8'h00, tcr_pkg::SUBREV_CODE};
			tcr_pkg::A_MS:      val16 = {14'h0000, ms_s2_r};
			tcr_pkg::A_PH0_LO:  val16 = {4'h0, ph0_r};
			tcr_pkg::A_PH1_LO:  val16 = {4'h0, ph1_r};
			tcr_pkg::A_FILL:    val16 = {12'h000, fill_r};
			tcr_pkg::A_LEAK:    val16 = {12'h000, leak_r};
			tcr_pkg::A_BKT:     val16 = {10'h000, bkt_r};
			tcr_pkg::A_ASET:    val16 = {10'h000, aset_r};
			tcr_pkg::A_ACLR:    val16 = {10'h000, aclr_r};
			tcr_pkg::A_TRIM_LO: val16 = {5'h00, trim_r};
			tcr_pkg::A_REJ_LO:  val16 = {5'h00, rej_r};
			tcr_pkg::A_ACC_LO:  val16 = {5'h00, acc_r};
			tcr_pkg::A_MODE0:   val16 = {10'h000, mode0_r};
			tcr_pkg::A_EVT_LO:  val16 = evt_r;
			default:            val16 = 16'h0000;
		endcase
	end

	// Read side: drive data, snapshot upper byte on low byte read
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ad_r      <= 8'h00;
			ad_oe_n_r <= 1'b1;
			rd_hold_r <= 8'h00;
		end else begin
			ad_oe_n_r <= !rd_act;
			if (rd_take) begin
				ad_r <= r_is_hi ? rd_hold_r : val16[7:0];
				if (r_is_lo) begin
					rd_hold_r <= val16[15:8];
				end
			end
		end
	end

	// Write side: low byte held, upper byte commits
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_hold_r <= 8'h00;
			ph0_r     <= tcr_pkg::RST_PHASE;
			ph1_r     <= tcr_pkg::RST_PHASE;
			fill_r    <= tcr_pkg::RST_FILL;
			leak_r    <= tcr_pkg::RST_LEAK;
			bkt_r     <= tcr_pkg::RST_BKT;
			aset_r    <= tcr_pkg::RST_ASET;
			aclr_r    <= tcr_pkg::RST_ACLR;
			trim_r    <= tcr_pkg::RST_TRIM;
			rej_r     <= tcr_pkg::RST_REJ;
			acc_r     <= tcr_pkg::RST_ACC;
			mode0_r   <= tcr_pkg::RST_MODE0;
		end else if (wr_at) begin
			if (w_is_lo) begin
				wr_hold_r <= wdata;
			end
			case (waddr)
				tcr_pkg::A_PH0_HI:  ph0_r  <= wval[11:0];
				tcr_pkg::A_PH1_HI:  ph1_r  <= wval[11:0];
				tcr_pkg::A_FILL:    fill_r <= wdata[3:0];
				tcr_pkg::A_LEAK:    leak_r <= wdata[3:0];
				tcr_pkg::A_BKT:     if (bkt_ok) bkt_r <= wdata[5:0];
				tcr_pkg::A_ASET:    if (aset_ok) aset_r <= wdata[5:0];
				tcr_pkg::A_ACLR:    if (aclr_ok) aclr_r <= wdata[5:0];
				tcr_pkg::A_TRIM_HI: trim_r <= wval[10:0];
				tcr_pkg::A_REJ_HI:  rej_r  <= wval[10:0];
				tcr_pkg::A_ACC_HI:  acc_r  <= wval[10:0];
				tcr_pkg::A_MODE0:   mode0_r <= wdata[5:0];
				default:            ;
			endcase
		end
	end

	// Event flags: new events win over a clear in the same cycle
	assign evt_nxt = (evt_r & ~evt_clr) | i_event;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			evt_r <= 16'h0000;
		end else begin
			evt_r <= evt_nxt;
		end
	end

	// Activity monitor timing strobes
	wire ms_tick   = ms_cnt_r == 15'(P_MS_CYCLES - 1);
	wire fill_end  = ms_tick && (fill_cnt_r == fill_r);
	wire leak_end  = fill_end && (leak_cnt_r == leak_r);
	wire fill_hit  = seen_r || act_s2_r;

	// Bucket level: fill on active window, leak per leak window, cap
	always_comb begin
		bucket_nxt = bucket_r;
		if (fill_end) begin
			if (fill_hit && bucket_r < bkt_r) begin
				bucket_nxt = bucket_r + 6'h01;
			end
			if (leak_end && bucket_nxt != 6'h00) begin
				bucket_nxt = bucket_nxt - 6'h01;
			end
		end
		if (bucket_nxt > bkt_r) begin
			bucket_nxt = bkt_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ms_cnt_r   <= 15'h0000;
			fill_cnt_r <= 4'h0;
			leak_cnt_r <= 4'h0;
			seen_r     <= 1'b0;
			bucket_r   <= 6'h00;
			alarm_r    <= 1'b0;
		end else begin
			ms_cnt_r   <= ms_tick ? 15'h0000 : ms_cnt_r + 15'h0001;
			if (ms_tick) begin
				fill_cnt_r <= fill_end ? 4'h0 : fill_cnt_r + 4'h1;
			end
			if (fill_end) begin
				leak_cnt_r <= leak_end ? 4'h0 : leak_cnt_r + 4'h1;
			end
			seen_r   <= fill_end ? 1'b0 : fill_hit;
			bucket_r <= bucket_nxt;
			if (bucket_r >= aset_r) begin
				alarm_r <= 1'b1;
			end else if (bucket_r <= aclr_r) begin
				alarm_r <= 1'b0;
			end
		end
	end

	// Pull-in limit: in manual mode a reference beyond range is followed only if allowed
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			follow_r <= 1'b0;
		end else begin
			follow_r <= mode0_r[tcr_pkg::MODE_AUTO_BIT] || (i_ref_offset <= rej_r) ||
				mode0_r[tcr_pkg::MODE_OOP_BIT];
		end
	end

	// Outputs straight from flip-flops
	assign o_bus_ad         = ad_r;
	assign o_bus_ad_oe_n    = ad_oe_n_r;
	assign o_gen0_phase_adj = ph0_r;
	assign o_gen1_phase_adj = ph1_r;
	assign o_freerun_trim   = trim_r;
	assign o_reject_range   = rej_r;
	assign o_accept_range   = acc_r;
	assign o_gen0_mode      = mode0_r;
	assign o_event          = evt_r;
	assign o_activity_alarm = alarm_r;
	assign o_ref_follow     = follow_r;

	// Checks
	AST_RD_SNAP: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rd_take && r_is_lo |=> rd_hold_r == $past(val16[15:8]))
		else $error("upper byte not snapshot on low byte read");
	AST_RD_HOLD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rd_take && r_is_hi |=> o_bus_ad == $past(rd_hold_r))
		else $error("upper byte read did not return held value");
	AST_WR_DEFER: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_take && waddr == tcr_pkg::A_PH0_LO |=> $stable(ph0_r))
		else $error("low byte write changed target early");
	AST_WR_COMMIT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_take && waddr == tcr_pkg::A_PH0_HI |=> ph0_r == $past(wval[11:0]))
		else $error("upper byte write did not commit held value");
	AST_EVT_STICKY: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		i_event[0] |=> evt_r[0] ##1 (evt_r[0] || $past(evt_clr[0])))
		else $error("event flag lost");
	AST_MS_PINS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rd_take && raddr == tcr_pkg::A_MS |=> o_bus_ad == {6'h00, $past(ms_s2_r)})
		else $error("master/slave status wrong");
	AST_BKT_REJECT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_take && waddr == tcr_pkg::A_BKT && !bkt_ok |=> $stable(bkt_r))
		else $error("invalid bucket size stored");
	AST_LEVELS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		aclr_r < aset_r && aset_r <= bkt_r)
		else $error("alarm levels out of order");
	AST_ALARM: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		bucket_r >= aset_r |=> alarm_r)
		else $error("alarm not raised at set level");
	AST_FOLLOW: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!mode0_r[tcr_pkg::MODE_AUTO_BIT] && !mode0_r[tcr_pkg::MODE_OOP_BIT] &&
		i_ref_offset > rej_r |=> !o_ref_follow)
		else $error("reference followed beyond pull-in");
	COV_MB_WRITE: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_take && waddr == tcr_pkg::A_PH0_HI);
	COV_EVT_CLR: cover property (@(posedge i_clk) disable iff (!i_arst_n) evt_clr != 16'h0000);
	COV_ALARM: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(alarm_r));

endmodule // tcr_register_bank

// *** sim/tcr_host_model.sv ***
`timescale 1ns/1ps

module tcr_host_model (
	// Clock, read data and its enable
	input  wire logic [7:0]    i_rdata,
	input  wire logic          i_oe_n,
	input  wire logic          i_clk,
	// Bus pins
	output tcr_pkg::tcr_pins_s o_pins
);

	// Strobes idle high at time zero
	initial begin
		o_pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 7'h7F, data: 8'h00};
	end

	// Wait a number of falling edges
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	// Byte read; strobes held four periods, data taken before release
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic oe);
		o_pins.addr = a;
		o_pins.cs_n = 1'b0;
		o_pins.rd_n = 1'b0;
		cyc(4);
		d = i_rdata;
		oe = i_oe_n;
		o_pins.rd_n = 1'b1;
		o_pins.cs_n = 1'b1;
		cyc(4);
	endtask

	// Byte write; select and data outlast the write strobe
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		o_pins.addr = a;
		o_pins.data = d;
		o_pins.cs_n = 1'b0;
		o_pins.wr_n = 1'b0;
		cyc(4);
		o_pins.wr_n = 1'b1;
		cyc(4);
		o_pins.cs_n = 1'b1;
		o_pins.data = ~d; // Released bus shows no stale value
		cyc(4);
	endtask

	// Two-byte write, low byte first then ascending
	task automatic wr16(input logic [6:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 7'h01, v[15:8]);
	endtask

endmodule // tcr_host_model

// *** sim/tcr_register_bank_bench.sv ***
`timescale 1ns/1ps

module tcr_register_bank_bench;

	logic               i_clk;
	logic               i_arst_n;
	logic [1:0]         i_ms_sel;
	logic               i_ref_activity;
	logic [15:0]        i_event;
	logic [10:0]        i_ref_offset;
	tcr_pkg::tcr_pins_s pins;
	logic [7:0]         o_bus_ad;
	logic [11:0]        ph0;
	logic [11:0]        ph1;
	logic [10:0]        trim;
	logic [10:0]        rej;
	logic [10:0]        acc;
	logic [15:0]        evt;
	logic               alarm;
	logic               follow;
	logic               oe_n;
	logic [5:0]         mode;
	int                 failures;
	int                 checks_done;
	int                 n;

	// Reset readback table: address and expected byte
	localparam logic [14:0] RST_TAB [22] = '{15'h00C3, 15'h01A5, 15'h025A, 15'h033C,
		15'h0401, 15'h0500, 15'h0600, 15'h0700, 15'h0800, 15'h0901, 15'h0A03,
		15'h0B14, 15'h0C0F, 15'h0D0A, 15'h0E00, 15'h0F00, 15'h106E, 15'h1100,
		15'h1264, 15'h1300, 15'h1C00, 15'h2000};
	// Write table: address, data written, expected readback
	localparam logic [22:0] WR_TAB [13] = '{23'h0B0E14, 23'h0B0F0F, 23'h0C100F,
		23'h0C0A0F, 23'h0C0B0B, 23'h0D0B0A, 23'h0D0505, 23'h0B3F3F, 23'h090F0F,
		23'h0A0000, 23'h0A0F0F, 23'h090000, 23'h0A0303};

	tcr_register_bank #(.P_MS_CYCLES(20)) tcr_register_bank_i (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus_cs_n(pins.cs_n),
		.i_bus_rd_n(pins.rd_n), .i_bus_wr_n(pins.wr_n), .i_bus_addr(pins.addr),
		.i_bus_ad(pins.data), .o_bus_ad(o_bus_ad), .o_bus_ad_oe_n(oe_n),
		.i_ms_sel(i_ms_sel), .i_ref_activity(i_ref_activity), .i_event(i_event),
		.i_ref_offset(i_ref_offset), .o_gen0_phase_adj(ph0), .o_gen1_phase_adj(ph1),
		.o_freerun_trim(trim), .o_reject_range(rej), .o_accept_range(acc),
		.o_gen0_mode(mode), .o_event(evt), .o_activity_alarm(alarm), .o_ref_follow(follow)
	);

	tcr_host_model tcr_host_model_i (
		.i_rdata(o_bus_ad),
		.i_oe_n(oe_n),
		.i_clk(i_clk),
		.o_pins(pins)
	);

	// Clock generation
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// Output compare
	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Read data compare
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		chk_out({8'h00, got}, {8'h00, exp});
	endtask

	// Read one byte and compare
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       oe;
		tcr_host_model_i.rd(a, d, oe);
		chk_byte(d, e);
		chk_out({15'h0000, oe}, 16'h0000);
		chk_out({15'h0000, oe_n}, 16'h0001);
	endtask

	// Bounded wait for an alarm level
	task automatic wait_alarm(input logic v);
		n = 0;
		while (alarm !== v && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		end_of_test();
	end

	// Test sequence
	initial begin
		failures = 0;
		checks_done = 0;
		i_arst_n = 1'b0;
		i_ms_sel = 2'b01;
		i_ref_activity = 1'b0;
		i_event = 16'h0000;
		i_ref_offset = 11'h000;
		repeat (20) @(negedge i_clk);
		i_arst_n = 1'b1;
		tcr_host_model_i.cyc(4);
		foreach (RST_TAB[k]) begin
			rdc(RST_TAB[k][14:8], RST_TAB[k][7:0]);
		end
		$display("test reset values done");
		tcr_host_model_i.wr(tcr_pkg::A_PH0_LO, 8'hFF);
		chk_out({4'h0, ph0}, 16'h0000);
		tcr_host_model_i.wr(tcr_pkg::A_PH0_HI, 8'h0F);
		chk_out({4'h0, ph0}, 16'h0FFF);
		tcr_host_model_i.wr16(tcr_pkg::A_PH1_LO, 16'h0ABC);
		chk_out({4'h0, ph1}, 16'h0ABC);
		tcr_host_model_i.wr16(tcr_pkg::A_TRIM_LO, 16'h0400);
		chk_out({5'h00, trim}, 16'h0400);
		tcr_host_model_i.wr16(tcr_pkg::A_REJ_LO, 16'h07FF);
		chk_out({5'h00, rej}, 16'h07FF);
		tcr_host_model_i.wr16(tcr_pkg::A_ACC_LO, 16'h07FF);
		chk_out({5'h00, acc}, 16'h07FF);
		$display("test multibyte writes done");
		rdc(tcr_pkg::A_REJ_LO, 8'hFF);
		tcr_host_model_i.wr16(tcr_pkg::A_REJ_LO, 16'h0123);
		rdc(tcr_pkg::A_REJ_HI, 8'h07);
		rdc(tcr_pkg::A_REJ_LO, 8'h23);
		rdc(tcr_pkg::A_REJ_HI, 8'h01);
		$display("test held read done");
		foreach (WR_TAB[k]) begin
			tcr_host_model_i.wr(WR_TAB[k][22:16], WR_TAB[k][15:8]);
			rdc(WR_TAB[k][22:16], WR_TAB[k][7:0]);
		end
		$display("test monitor settings done");
		i_ms_sel = 2'b10;
		tcr_host_model_i.cyc(4);
		rdc(tcr_pkg::A_MS, 8'h02);
		tcr_host_model_i.wr(tcr_pkg::A_MS, 8'hFF);
		rdc(tcr_pkg::A_MS, 8'h02);
		$display("test status done");
		i_event = 16'hFFFF;
		@(negedge i_clk);
		i_event = 16'h0000;
		tcr_host_model_i.cyc(2);
		chk_out(evt, 16'hFFFF);
		tcr_host_model_i.wr(tcr_pkg::A_EVT_LO, 8'h0F);
		chk_out(evt, 16'hFFFF);
		tcr_host_model_i.wr(tcr_pkg::A_EVT_HI, 8'hF0);
		chk_out(evt, 16'h0FF0);
		$display("test events done");
		i_ref_offset = 11'h124;
		tcr_host_model_i.cyc(3);
		chk_out({15'h0000, follow}, 16'h0000);
		i_ref_offset = 11'h123;
		tcr_host_model_i.cyc(3);
		chk_out({15'h0000, follow}, 16'h0001);
		i_ref_offset = 11'h124;
		tcr_host_model_i.wr(tcr_pkg::A_MODE0, 8'h20);
		chk_out({15'h0000, follow}, 16'h0001);
		chk_out({10'h000, mode}, 16'h0020);
		rdc(tcr_pkg::A_MODE0, 8'h20);
		tcr_host_model_i.wr(tcr_pkg::A_MODE0, 8'h00);
		chk_out({15'h0000, follow}, 16'h0000);
		chk_out({10'h000, mode}, 16'h0000);
		$display("test pull-in done");
		// Let window counters wrap onto the new fill and leak settings
		tcr_host_model_i.cyc(640);
		chk_out({15'h0000, alarm}, 16'h0000);
		i_ref_activity = 1'b1;
		wait_alarm(1'b1);
		i_ref_activity = 1'b0;
		chk_out({15'h0000, alarm}, 16'h0001);
		chk_out(16'(n >= 200 && n <= 400), 16'h0001);
		wait_alarm(1'b0);
		chk_out({15'h0000, alarm}, 16'h0000);
		chk_out(16'(n >= 400 && n <= 800), 16'h0001);
		$display("test activity alarm done");
		end_of_test();
	end

endmodule // tcr_register_bank_bench
